// ===== verilog/supply_fault_gpio_irq_status.v
// Purpose: Read-to-clear fault and pin flag registers with masked interrupt
// Assumes: APB slave, 100 MHz clk_i, asynchronous sources
// Notes: Zero wait states; unmapped addresses read zero, no error
//
// How it works
// - Under-voltage flags: linregs bits 11-8, bucks 5-0
// - Over-current flag at bit 15, rising edge
// - Thirteen pin flags at bits 12-0
// - Pin trigger chosen by per-pin configuration
// - Reading returns flags then clears them
// - Mask bit one hides flag from interrupt
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_regs.vh"
// Bus timing, edge by edge
//   setup edge: read word captured, flags of that word cleared, pready set
//   access edge: pready seen high, writes land, pready drops again
// Clearing on the capture edge means an event on that same edge is kept
// for the next read instead of vanishing unseen.
// Sources pass two flops and a history flop: a flag sets on the third edge
// after its source changes, and the interrupt follows one edge later.
// Limitation: a source pulse shorter than a clock period may be missed.
module supply_fault_gpio_irq_status #(
  parameter PINS = 13
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [3:0] linreg_undervolt_i,
  input wire [5:0] buck_undervolt_i,
  input wire limit_switch_overcurrent_i,
  input wire [PINS-1:0] pin_i,
  output reg irq_o
);
  reg [15:0] uv_mask_r;
  reg [15:0] oc_mask_r;
  reg [15:0] pin_mask_r;
  reg [PINS-1:0] trig_mode_r;
  reg [PINS-1:0] trig_pol_r;
  reg [31:0] rdata_nxt;
  wire [15:0] uv_flags;
  wire [15:0] oc_flags;
  wire [15:0] pin_flags;
  wire [15:0] uv_src;
  wire [15:0] oc_src;
  wire [15:0] pin_src;
  wire [15:0] pin_both;
  wire [15:0] pin_fall;
  wire [7:0] idx;
  wire acc;
  wire wr;
  wire mapped;
  wire setup;
  wire setup_rd;
  wire uv_clr;
  wire oc_clr;
  wire pin_clr;
  wire [15:0] uv_pending;
  wire [15:0] oc_pending;
  wire [15:0] pin_pending;

  // Word index from byte address
  // Alias bits are screened by the decode below
  function [7:0] word_index;
    input [11:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  // True when the decoded word index names the given register
  function hits;
    input [7:0] index;
    input [7:0] target;
    begin
      hits = (index == target);
    end
  endfunction

  // Only the low word window decodes; upper and byte-lane bits must be zero
  // so that no register shows up again at an alias address
  assign mapped = (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);
  assign idx = mapped ? word_index(paddr_i) : 8'hff;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;

  // Clear on the setup edge, the edge that captures the read word: an event
  // landing there is not in the returned word, so it must stay set. A clear
  // one edge later would drop it unreported.
  assign setup = psel_i & ~penable_i;
  assign setup_rd = setup & ~pwrite_i;
  assign uv_clr = setup_rd & hits(idx, `UV_STATUS_IDX);
  assign oc_clr = setup_rd & hits(idx, `OC_STATUS_IDX);
  assign pin_clr = setup_rd & hits(idx, `PIN_STATUS_IDX);

  // Source vectors placed at their register bit positions
  // Unused positions are zero and their flags are disabled as well
  assign uv_src = {4'h0, linreg_undervolt_i, 2'h0, buck_undervolt_i};
  assign oc_src = {limit_switch_overcurrent_i, 15'h0000};
  assign pin_src = {{(16-PINS){1'b0}}, pin_i};
  assign pin_both = {{(16-PINS){1'b0}}, trig_mode_r};
  assign pin_fall = {{(16-PINS){1'b0}}, trig_pol_r};

  // Under-voltage bank, rising edge only
  // Bits 15-12 and 7-6 are disabled and always read zero
  flag_cell #(.WIDTH(16)) uv_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src_i(uv_src),
    .enable_i(`UV_VALID_MASK),
    .both_i(16'h0000),
    .fall_i(16'h0000),
    .clear_i(uv_clr),
    .flags_o(uv_flags)
  );

  // Over-current bank, rising edge only
  // Only bit 15 is enabled
  flag_cell #(.WIDTH(16)) oc_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src_i(oc_src),
    .enable_i(`OC_VALID_MASK),
    .both_i(16'h0000),
    .fall_i(16'h0000),
    .clear_i(oc_clr),
    .flags_o(oc_flags)
  );

  // Pin bank, trigger set by configuration registers
  // Positions above the pin count are tied off and stay zero
  flag_cell #(.WIDTH(16)) pin_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src_i(pin_src),
    .enable_i(`PIN_VALID_MASK),
    .both_i(pin_both),
    .fall_i(pin_fall),
    .clear_i(pin_clr),
    .flags_o(pin_flags)
  );

  // Software-written mask and trigger configuration
  // Trigger per pin: mode one takes both edges; with mode zero the polarity
  // bit picks falling (one) or rising (zero). Changing either while a pin is
  // steady raises no flag, since only edges are seen.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uv_mask_r <= `MASK_RESET;
      oc_mask_r <= `MASK_RESET;
      pin_mask_r <= `MASK_RESET;
      trig_mode_r <= `TRIG_RESET;
      trig_pol_r <= `TRIG_RESET;
    end else if (wr) begin
      case (idx)
        `UV_MASK_IDX: uv_mask_r <= pwdata_i[15:0] & `UV_VALID_MASK;
        `OC_MASK_IDX: oc_mask_r <= pwdata_i[15:0] & `OC_VALID_MASK;
        `PIN_MASK_IDX: pin_mask_r <= pwdata_i[15:0] & `PIN_VALID_MASK;
        `PIN_TRIG_MODE_IDX: trig_mode_r <= pwdata_i[PINS-1:0];
        `PIN_TRIG_POL_IDX: trig_pol_r <= pwdata_i[PINS-1:0];
        default: trig_pol_r <= trig_pol_r;
      endcase
    end
  end

  // Read mux; status writes are ignored since flags clear on read only
  // Unmapped words and the upper half of every word read zero
  // Captured on the setup edge, so the word stands through the access
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (idx)
      `UV_STATUS_IDX: rdata_nxt = {16'h0000, uv_flags};
      `OC_STATUS_IDX: rdata_nxt = {16'h0000, oc_flags};
      `PIN_STATUS_IDX: rdata_nxt = {16'h0000, pin_flags};
      `UV_MASK_IDX: rdata_nxt = {16'h0000, uv_mask_r};
      `OC_MASK_IDX: rdata_nxt = {16'h0000, oc_mask_r};
      `PIN_MASK_IDX: rdata_nxt = {16'h0000, pin_mask_r};
      `PIN_TRIG_MODE_IDX: rdata_nxt = {{(32-PINS){1'b0}}, trig_mode_r};
      `PIN_TRIG_POL_IDX: rdata_nxt = {{(32-PINS){1'b0}}, trig_pol_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered APB answer: pready high in the first cycle of the access phase
  // No wait states and no error response; refused writes are just dropped
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= 1'b0;
      if (setup_rd) begin
        prdata_o <= rdata_nxt;
      end
    end
  end

  // Per-bank pending bits; a one in a mask hides that flag
  assign uv_pending = uv_flags & ~uv_mask_r;
  assign oc_pending = oc_flags & ~oc_mask_r;
  assign pin_pending = pin_flags & ~pin_mask_r;

  // Interrupt level from unmasked flags, registered
  // Registered so the pin comes straight from a flop, one edge after a flag
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(uv_pending | oc_pending | pin_pending);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/irq_status_regs.vh
// Purpose: Register map, field positions and reset values of the supply/pin flag bank
// Assumes: APB, 32-bit data, register index times four is the byte address
// Notes: Definitions only
`ifndef IRQ_STATUS_REGS_VH
`define IRQ_STATUS_REGS_VH

// Register indices (byte address is index times four)
`define UV_STATUS_IDX 8'h1c
`define OC_STATUS_IDX 8'h1d
`define PIN_STATUS_IDX 8'h1e
`define UV_MASK_IDX 8'h2c
`define OC_MASK_IDX 8'h2d
`define PIN_MASK_IDX 8'h2e
`define PIN_TRIG_MODE_IDX 8'h30
`define PIN_TRIG_POL_IDX 8'h31

// Field positions
`define UV_LINREG_LSB 8
`define UV_LINREG_MSB 11
`define UV_BUCK_LSB 0
`define UV_BUCK_MSB 5
`define OC_LIMIT_BIT 15
`define PIN_LSB 0
`define PIN_MSB 12

// Valid bit masks
`define UV_VALID_MASK 16'h0f3f
`define OC_VALID_MASK 16'h8000
`define PIN_VALID_MASK 16'h1fff

// Reset values
`define STATUS_RESET 16'h0000
`define MASK_RESET 16'h0000
`define TRIG_RESET 13'h0000

`endif

// ===== verilog/flag_cell.v
// Purpose: One bank of sticky event flags with synchronised sources
// Assumes: Sources are asynchronous levels; one clock
// Notes: Per-bit trigger select: mode 0 edge, 1 both edges; pol picks edge
`timescale 1ns/1ps
`default_nettype none
module flag_cell #(
  parameter WIDTH = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] src_i,
  input wire [WIDTH-1:0] enable_i,
  input wire [WIDTH-1:0] both_i,
  input wire [WIDTH-1:0] fall_i,
  input wire clear_i,
  output reg [WIDTH-1:0] flags_o
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg [WIDTH-1:0] prev_r;
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] fall;
  wire [WIDTH-1:0] event_hit;

  // Two-stage synchroniser, then a history stage for edge detection
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      prev_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= src_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
  // Trigger choice per bit; fixed banks tie both_i and fall_i low
  assign event_hit = enable_i & ((both_i & (rise | fall)) | (~both_i & ~fall_i & rise)
    | (~both_i & fall_i & fall));

  // New events win over a clearing read so none is lost
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      flags_o <= event_hit;
    end else begin
      flags_o <= flags_o | event_hit;
    end
  end
endmodule
`default_nettype wire

// ===== verification/irq_status_properties.sv
// Purpose: Port checker for the flag bank
// Assumes: Zero-wait APB slave, reads clear flags
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module irq_status_props (
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Read completions, by register index
  wire rd = pready_o && !pwrite_i;
  wire [7:0] idx = paddr_i[9:2];
  a_ready_access: assert property (psel_i && !penable_i |=> pready_o) else $error("late ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_framed: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
  a_no_error: assert property (!pslverr_o) else $error("error response");
  a_uv_unused: assert property (rd && idx == 8'h1c |-> (prdata_o & 32'hfffff0c0) == 32'h0)
    else $error("uv unused bit set");
  a_oc_unused: assert property (rd && idx == 8'h1d |-> (prdata_o & 32'hffff7fff) == 32'h0)
    else $error("oc unused bit set");
  a_pin_unused: assert property (rd && idx == 8'h1e |-> (prdata_o & 32'hffffe000) == 32'h0)
    else $error("pin unused bit set");
  // Interrupt only drops after a completed access
  a_irq_cause: assert property ($fell(irq_o) |-> $past(pready_o)) else $error("irq fell");
  a_rdata_hold: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data moved");
  cover property (rd && idx == 8'h1c && prdata_o[8]);
  cover property ($rose(irq_o));
  cover property (pready_o ##1 psel_i && !penable_i ##1 pready_o);
endmodule
bind supply_fault_gpio_irq_status irq_status_props u_props (.clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .irq_o);
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Directed bench for the flag bank
// Assumes: Masks at 0xb0, trigger mode 0xc0, polarity 0xc4
// Notes: Sources are levels; flags need three edges to show, the interrupt four
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic limit_switch_overcurrent_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic [3:0] linreg_undervolt_i = 4'h0;
  logic [5:0] buck_undervolt_i = 6'h0;
  logic [12:0] pin_i = 13'h0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o;
  int error_cnt = 0, n_checks = 0;
  supply_fault_gpio_irq_status dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .linreg_undervolt_i,
    .buck_undervolt_i, .limit_switch_overcurrent_i, .pin_i, .irq_o);
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; bb keeps psel up so a setup follows at once
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic bb);
    int n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    rd = prdata_o;
    penable_i <= 1'b0;
    if (!bb) begin
      psel_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e, logic bb);
    apb(1'b0, a, 32'h0, bb);
    chk(nm, rd, e);
  endtask
  // Sequence of scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc("uv", 12'h070, 32'h0, 0);
    rdc("oc", 12'h074, 32'h0, 0);
    rdc("pin", 12'h078, 32'h0, 0);
    linreg_undervolt_i <= 4'hf;
    buck_undervolt_i <= 6'h3f;
    limit_switch_overcurrent_i <= 1'b1;
    pin_i <= 13'h1fff;
    repeat (5) @(posedge clk_i);
    chk("irq", irq_o, 32'h1);
    rdc("uv", 12'h070, 32'h0f3f, 1);
    rdc("uv", 12'h070, 32'h0, 0);
    rdc("oc", 12'h074, 32'h8000, 0);
    rdc("oc", 12'h074, 32'h0, 0);
    rdc("pin", 12'h078, 32'h1fff, 0);
    apb(1'b1, 12'h074, 32'hffff, 0);
    rdc("gap", 12'h3fc, 32'h0, 0);
    rdc("oc", 12'h074, 32'h0, 0);
    // Event lands on the clearing edge: absent from this read, kept for the next
    limit_switch_overcurrent_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    limit_switch_overcurrent_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rdc("oc race", 12'h074, 32'h0, 0);
    rdc("oc kept", 12'h074, 32'h8000, 0);
    apb(1'b1, 12'h0b0, 32'h0f3f, 0);
    rdc("mask", 12'h0b0, 32'h0f3f, 0);
    linreg_undervolt_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    linreg_undervolt_i <= 4'hf;
    repeat (5) @(posedge clk_i);
    chk("irq", irq_o, 32'h0);
    rdc("uv", 12'h070, 32'h0f00, 0);
    // Falling edges, then rising edges in both-edge mode, per pin
    apb(1'b1, 12'h0c4, 32'h1fff, 0);
    pin_i <= 13'h0;
    repeat (5) @(posedge clk_i);
    rdc("pin", 12'h078, 32'h1fff, 0);
    apb(1'b1, 12'h0c0, 32'h1fff, 0);
    pin_i <= 13'h1fff;
    repeat (5) @(posedge clk_i);
    rdc("pin", 12'h078, 32'h1fff, 0);
    chk("irq", irq_o, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
